//--- hw/cupwm_defs.vh
/*
  Constants of the compare unit PWM block: register offsets, field
  positions, mode codes, status bits and reset values.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef CUPWM_DEFS_VH
`define CUPWM_DEFS_VH

////////////////////////////////////////////////////////////////////////
// Register offsets (byte addresses on the plain register port)
`define CUPWM_OFF_CTL_ONE 8'h00
`define CUPWM_OFF_CTL_TWO 8'h04
`define CUPWM_OFF_DUTY 8'h08
`define CUPWM_OFF_PERIOD 8'h0C
`define CUPWM_OFF_STATUS 8'h10
`define CUPWM_OFF_MASK 8'h14
`define CUPWM_OFF_COUNT 8'h18

////////////////////////////////////////////////////////////////////////
// compare_control_one fields
`define CUPWM_MODE_HI 2
`define CUPWM_MODE_LO 0
`define CUPWM_FLT_HI 9
`define CUPWM_FLT_LO 7
`define CUPWM_TCS_HI 12
`define CUPWM_TCS_LO 10
`define CUPWM_CTL_ONE_MASK 16'h1F87

// compare_control_two fields
`define CUPWM_SYNC_HI 4
`define CUPWM_SYNC_LO 0
`define CUPWM_TRIG_BIT 7
`define CUPWM_CTL_TWO_MASK 16'h009F

////////////////////////////////////////////////////////////////////////
// Codes
`define CUPWM_MODE_OFF 3'h0
`define CUPWM_MODE_EDGE 3'h6
`define CUPWM_MODE_CENTER 3'h7
`define CUPWM_SYNC_SELF 5'h1F
`define CUPWM_TCS_SYSCLK 3'h7

////////////////////////////////////////////////////////////////////////
// Status and mask bits
`define CUPWM_ST_PERIOD 0
`define CUPWM_ST_DUTY 1
`define CUPWM_ST_FAULT 2
`define CUPWM_ST_W 3

////////////////////////////////////////////////////////////////////////
// Reset values
`define CUPWM_RST_CTL_ONE 16'h0000
`define CUPWM_RST_CTL_TWO 16'h0000
`define CUPWM_RST_VALUE 16'h0000
`define CUPWM_RST_STATUS 3'h0
`define CUPWM_RST_MASK 3'h0

`endif

//--- hw/cupwm_chan.v
/*
  One compare channel: the software-visible value register, the internal
  buffer that the comparator really uses, and the equality match.
  Assumes the parent pulses load only at a period boundary or while idle.
*/
`timescale 1ns/1ps
`include "cupwm_defs.vh"

module cupwm_chan #(
  parameter CNT_W = 16
) (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Software side
  input wire wr_en,
  input wire [CNT_W-1:0] wr_data,
  output reg [CNT_W-1:0] soft_val_reg,
  // Compare side
  input wire load,
  input wire [CNT_W-1:0] count,
  output reg [CNT_W-1:0] active_val_reg,
  output wire match
);

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      soft_val_reg <= `CUPWM_RST_VALUE;
      active_val_reg <= `CUPWM_RST_VALUE;
    end else begin
      if (wr_en) begin
        soft_val_reg <= wr_data;
      end
      // Buffer copy only at a boundary or while idle, so a pulse is never cut short
      if (load) begin
        active_val_reg <= soft_val_reg; // [RQ2] [RQ16]
      end
    end
  end

  assign match = (count == active_val_reg);

endmodule // cupwm_chan

//--- hw/cupwm_top.v
/*
  Compare unit in PWM mode: register file, clock-source choice, counter,
  edge- and center-aligned waveform, fault gating and interrupt.
  Assumes synchronous inputs on ref_clk, one-cycle prescaler ticks and a
  single-cycle register master that never waits.
*/
// Local design decisions: the plain strobed port and the placing of the registers.
// Operation
// RQ1: Edge-aligned or center-aligned waveform by configuration.
// RQ2: Settings double-buffered inside, buffers not addressable.
// RQ3: Duty taken from duty_compare_value register.
// RQ4: Period taken from period_compare_value register.
// RQ5: Sync select 0x1F, trigger clear: self sync.
// RQ6: timer_clock_select bits 12:10 choose counting clock.
// RQ7: compare_mode_field bits 2:0 choose PWM mode.
// RQ8: Fault inputs enabled individually; disabled ones ignored.
// RQ9: Software enables compare interrupt for fault handling.
// RQ10: Counter clocked by timer prescaler output.
// RQ11: Software routes output through pin_remap_select.
// RQ12: Software sets clocking timer prescale value.
// RQ13: Output default, opposite on duty match.
// RQ14: Output back to default on period match.
// RQ15: Interrupt flag set on every period match.
// RQ16: New values take effect at period boundary.
// RQ17: Self sync: counter restarts on period match.
`timescale 1ns/1ps
`include "cupwm_defs.vh"

module cupwm_top #(
  parameter CNT_W = 16,
  parameter TICK_N = 7,
  parameter FLT_N = 3
) (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [CNT_W-1:0] reg_wr_data,
  input wire reg_wr_strobe,
  input wire reg_rd_strobe,
  output reg [CNT_W-1:0] reg_rd_data_reg,
  // Clock sources and sync
  input wire [TICK_N-1:0] timer_prescale_tick,
  input wire ext_sync_pulse,
  // Faults
  input wire [FLT_N-1:0] fault_in,
  // Output and interrupt
  output reg compare_output_pin_reg,
  output wire compare_irq
);

  // Counter phases of the waveform generator
  localparam PH_IDLE = 3'b001;
  localparam PH_UP = 3'b010;
  localparam PH_DOWN = 3'b100;

  ////////////////////////////////////////////////////////////////////////
  // Register file

  reg [CNT_W-1:0] ctl_one_reg;
  reg [CNT_W-1:0] ctl_two_reg;
  reg [`CUPWM_ST_W-1:0] status_reg;
  reg [`CUPWM_ST_W-1:0] status_next;
  reg [`CUPWM_ST_W-1:0] mask_reg;
  reg [CNT_W-1:0] rd_data_next;
  reg [CNT_W-1:0] cnt_reg;
  reg [CNT_W-1:0] cnt_next;
  reg [2:0] phase_reg;
  reg [2:0] phase_next;
  reg out_next;
  reg fault_latch_reg;
  reg fault_latch_next;
  reg armed_reg;
  reg boundary;
  reg tick;

  wire [CNT_W-1:0] duty_soft;
  wire [CNT_W-1:0] period_soft;
  wire [CNT_W-1:0] duty_active;
  wire [CNT_W-1:0] period_active;
  wire duty_match;
  wire period_match;

  wire wr_ctl_one = reg_wr_strobe && (reg_addr == `CUPWM_OFF_CTL_ONE);
  wire wr_ctl_two = reg_wr_strobe && (reg_addr == `CUPWM_OFF_CTL_TWO);
  wire wr_duty = reg_wr_strobe && (reg_addr == `CUPWM_OFF_DUTY);
  wire wr_period = reg_wr_strobe && (reg_addr == `CUPWM_OFF_PERIOD);
  wire wr_mask = reg_wr_strobe && (reg_addr == `CUPWM_OFF_MASK);
  wire rd_status = reg_rd_strobe && (reg_addr == `CUPWM_OFF_STATUS);

  wire [2:0] mode = ctl_one_reg[`CUPWM_MODE_HI:`CUPWM_MODE_LO]; // [RQ7]
  wire [2:0] clk_sel = ctl_one_reg[`CUPWM_TCS_HI:`CUPWM_TCS_LO];
  wire [FLT_N-1:0] flt_en = ctl_one_reg[`CUPWM_FLT_HI:`CUPWM_FLT_LO];
  wire [4:0] sync_sel = ctl_two_reg[`CUPWM_SYNC_HI:`CUPWM_SYNC_LO];
  wire trig_mode = ctl_two_reg[`CUPWM_TRIG_BIT];

  wire mode_edge = (mode == `CUPWM_MODE_EDGE); // [RQ1]
  wire mode_center = (mode == `CUPWM_MODE_CENTER); // [RQ1]
  wire pwm_on = mode_edge || mode_center;
  // Self sync needs the trigger bit clear, else the unit waits for ext_sync_pulse
  wire self_sync = (sync_sel == `CUPWM_SYNC_SELF) && !trig_mode; // [RQ5]
  wire ext_sync = !self_sync && !trig_mode && ext_sync_pulse;
  wire running = pwm_on && (!trig_mode || armed_reg);

  // Only enabled fault lines count; others are masked off here
  wire fault_active = |(fault_in & flt_en); // [RQ8]

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ctl_one_reg <= `CUPWM_RST_CTL_ONE;
      ctl_two_reg <= `CUPWM_RST_CTL_TWO;
      mask_reg <= `CUPWM_RST_MASK;
      status_reg <= `CUPWM_RST_STATUS;
      reg_rd_data_reg <= `CUPWM_RST_VALUE;
    end else begin
      if (wr_ctl_one) begin
        ctl_one_reg <= reg_wr_data & `CUPWM_CTL_ONE_MASK;
      end
      if (wr_ctl_two) begin
        ctl_two_reg <= reg_wr_data & `CUPWM_CTL_TWO_MASK;
      end
      if (wr_mask) begin
        mask_reg <= reg_wr_data[`CUPWM_ST_W-1:0];
      end
      status_reg <= status_next;
      reg_rd_data_reg <= rd_data_next;
    end
  end

  // Read data stand for exactly one cycle after the strobe
  always @* begin
    rd_data_next = {CNT_W{1'b0}};
    if (reg_rd_strobe) begin
      if (reg_addr == `CUPWM_OFF_CTL_ONE) begin
        rd_data_next = ctl_one_reg;
      end else if (reg_addr == `CUPWM_OFF_CTL_TWO) begin
        rd_data_next = ctl_two_reg;
      end else if (reg_addr == `CUPWM_OFF_DUTY) begin
        rd_data_next = duty_soft; // [RQ3]
      end else if (reg_addr == `CUPWM_OFF_PERIOD) begin
        rd_data_next = period_soft; // [RQ4]
      end else if (reg_addr == `CUPWM_OFF_STATUS) begin
        rd_data_next = {{(CNT_W-`CUPWM_ST_W){1'b0}}, status_reg};
      end else if (reg_addr == `CUPWM_OFF_MASK) begin
        rd_data_next = {{(CNT_W-`CUPWM_ST_W){1'b0}}, mask_reg};
      end else if (reg_addr == `CUPWM_OFF_COUNT) begin
        rd_data_next = cnt_reg;
      end else begin
        rd_data_next = {CNT_W{1'b0}};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare channels

  cupwm_chan #(
    .CNT_W(CNT_W)
  ) u_duty (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr_en(wr_duty),
    .wr_data(reg_wr_data),
    .soft_val_reg(duty_soft),
    .load(boundary || !running),
    .count(cnt_reg),
    .active_val_reg(duty_active),
    .match(duty_match)
  );

  cupwm_chan #(
    .CNT_W(CNT_W)
  ) u_period (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr_en(wr_period),
    .wr_data(reg_wr_data),
    .soft_val_reg(period_soft),
    .load(boundary || !running),
    .count(cnt_reg),
    .active_val_reg(period_active),
    .match(period_match)
  );

  ////////////////////////////////////////////////////////////////////////
  // Counting clock

  // Prescaler ticks (select codes 0 to 6), not the timers' own count outputs, drive the counter; code 7 counts every ref_clk cycle
  always @* begin
    tick = 1'b0;
    if (clk_sel == `CUPWM_TCS_SYSCLK) begin
      tick = 1'b1;
    end else if (clk_sel < TICK_N) begin
      tick = timer_prescale_tick[clk_sel]; // [RQ6] [RQ10]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter and waveform

  always @* begin
    cnt_next = cnt_reg;
    phase_next = phase_reg;
    out_next = compare_output_pin_reg;
    boundary = 1'b0;
    case (phase_reg)
      PH_IDLE: begin
        cnt_next = {CNT_W{1'b0}};
        out_next = 1'b0;
        if (running) begin
          phase_next = PH_UP;
        end
      end
      PH_UP: begin
        if (!running) begin
          // Mode off drops the pin at once, not a cycle late
          phase_next = PH_IDLE;
          cnt_next = {CNT_W{1'b0}};
          out_next = 1'b0;
        end else if (ext_sync) begin
          // Foreign sync source restarts the period
          cnt_next = {CNT_W{1'b0}};
          out_next = 1'b0;
          boundary = 1'b1;
        end else if (tick) begin
          if (duty_match) begin
            out_next = 1'b1; // [RQ13]
          end
          if (mode_center && period_match) begin
            phase_next = PH_DOWN;
            if (cnt_reg != {CNT_W{1'b0}}) begin
              cnt_next = cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
            end
          end else if (period_match) begin
            out_next = 1'b0; // [RQ14]
            if (self_sync) begin
              cnt_next = {CNT_W{1'b0}}; // [RQ17]
              boundary = 1'b1; // [RQ16]
            end else begin
              cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
            end
          end else begin
            cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
      end
      PH_DOWN: begin
        if (!running) begin
          phase_next = PH_IDLE;
          cnt_next = {CNT_W{1'b0}};
          out_next = 1'b0;
        end else if (ext_sync) begin
          cnt_next = {CNT_W{1'b0}};
          out_next = 1'b0;
          phase_next = PH_UP;
          boundary = 1'b1;
        end else if (tick) begin
          if (duty_match) begin
            out_next = 1'b0; // [RQ13]
          end
          if (cnt_reg == {CNT_W{1'b0}}) begin
            // Turning point at zero is the center-aligned boundary
            phase_next = PH_UP;
            boundary = 1'b1; // [RQ16]
            if (period_active != {CNT_W{1'b0}}) begin
              cnt_next = {{(CNT_W-1){1'b0}}, 1'b1};
            end
          end else begin
            cnt_next = cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
      end
      default: begin
        phase_next = PH_IDLE;
        cnt_next = {CNT_W{1'b0}};
        out_next = 1'b0;
      end
    endcase
    // A fault forces the default level until a clean boundary
    if (fault_active || fault_latch_reg) begin
      out_next = 1'b0; // [RQ8]
    end
  end

  always @* begin
    fault_latch_next = fault_latch_reg;
    if (fault_active) begin
      fault_latch_next = 1'b1;
    end else if (boundary || !running) begin
      fault_latch_next = 1'b0;
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_reg <= {CNT_W{1'b0}};
      phase_reg <= PH_IDLE;
      compare_output_pin_reg <= 1'b0;
      fault_latch_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
      compare_output_pin_reg <= out_next;
      fault_latch_reg <= fault_latch_next;
      // Trigger mode holds the counter until ext_sync_pulse fires, whatever sync_sel holds
      if (!pwm_on || !trig_mode) begin
        armed_reg <= 1'b0;
      end else if (ext_sync_pulse) begin
        armed_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status

  wire in_count = running && !ext_sync && tick && (phase_reg != PH_IDLE);
  wire ev_period = in_count && (phase_reg == PH_UP) && period_match;
  wire ev_duty = in_count && duty_match;

  // Read clears, but an event in the same cycle still lands
  always @* begin
    status_next = status_reg;
    if (rd_status) begin
      status_next = {`CUPWM_ST_W{1'b0}};
    end
    if (ev_period) begin
      status_next[`CUPWM_ST_PERIOD] = 1'b1; // [RQ15]
    end
    if (ev_duty) begin
      status_next[`CUPWM_ST_DUTY] = 1'b1;
    end
    if (fault_active) begin
      status_next[`CUPWM_ST_FAULT] = 1'b1;
    end
  end

  // Fault reporting reaches this line only while its mask bit is set; a status read shows it always
  assign compare_irq = |(status_reg & mask_reg); // [RQ9]

endmodule // cupwm_top

//--- test/cupwm_sva.sv
/*
  Port-level checker for the compare unit PWM block.
  Assumes binding onto cupwm_top and the single-cycle register port.
*/
`timescale 1ns/1ps
`include "cupwm_defs.vh"

module cupwm_sva #(
  parameter CNT_W = 16,
  parameter FLT_N = 3
) (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [CNT_W-1:0] reg_wr_data,
  input wire reg_wr_strobe,
  input wire reg_rd_strobe,
  input wire [CNT_W-1:0] reg_rd_data_reg,
  // Pins
  input wire [FLT_N-1:0] fault_in,
  input wire compare_output_pin_reg,
  input wire compare_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////
  // Shadow of software writes, mirrored from the port
  reg [2:0] mode_reg, flt_reg, mask_reg;
  reg [CNT_W-1:0] duty_reg, per_reg, two_reg;
  wire run = (mode_reg == `CUPWM_MODE_EDGE) || (mode_reg == `CUPWM_MODE_CENTER);
  wire unmapped = (reg_addr > `CUPWM_OFF_COUNT) || (reg_addr[1:0] != 2'h0);
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      mode_reg <= 3'h0;
      flt_reg <= 3'h0;
      mask_reg <= 3'h0;
      duty_reg <= '0;
      per_reg <= '0;
      two_reg <= '0;
    end else if (reg_wr_strobe) begin
      if (reg_addr == `CUPWM_OFF_CTL_ONE) begin
        mode_reg <= reg_wr_data[2:0];
        flt_reg <= reg_wr_data[9:7];
      end
      if (reg_addr == `CUPWM_OFF_MASK) mask_reg <= reg_wr_data[2:0];
      if (reg_addr == `CUPWM_OFF_DUTY) duty_reg <= reg_wr_data;
      if (reg_addr == `CUPWM_OFF_PERIOD) per_reg <= reg_wr_data;
      if (reg_addr == `CUPWM_OFF_CTL_TWO) two_reg <= reg_wr_data & 16'h009F;
    end
  end

  ////////////////////////////////////////////////////////////////////
  a_rd_idle_zero: assert property (!$past(reg_rd_strobe) |-> reg_rd_data_reg == '0)
    else $error("read data not zero outside read cycle");
  a_unmapped_rd: assert property (reg_rd_strobe && unmapped |=> reg_rd_data_reg == '0)
    else $error("unmapped read not zero");
  a_duty_readback: assert property (reg_rd_strobe && reg_addr == `CUPWM_OFF_DUTY |=> reg_rd_data_reg == duty_reg)
    else $error("duty readback wrong");
  a_period_readback: assert property (reg_rd_strobe && reg_addr == `CUPWM_OFF_PERIOD |=> reg_rd_data_reg == per_reg)
    else $error("period readback wrong");
  a_sync_readback: assert property (reg_rd_strobe && reg_addr == `CUPWM_OFF_CTL_TWO |=> reg_rd_data_reg == two_reg)
    else $error("control two readback wrong");
  a_off_pin_low: assert property (!run && $past(!run) |-> !compare_output_pin_reg)
    else $error("pin high while mode off");
  a_fault_pin_low: assert property (|(fault_in & flt_reg) |-> ##[1:2] !compare_output_pin_reg)
    else $error("pin high under enabled fault");
  a_irq_masked: assert property (compare_irq |-> mask_reg != 3'h0)
    else $error("interrupt with all sources masked");
  a_rise_when_run: assert property ($rose(compare_output_pin_reg) |-> $past(run))
    else $error("pin rose outside pwm mode");

  c_pin_rise: cover property ($rose(compare_output_pin_reg));
  c_irq: cover property ($rose(compare_irq));
  c_fault: cover property (|(fault_in & flt_reg));
endmodule // cupwm_sva

//--- test/cupwm_load.sv
/*
  External load on the compare output pin: counts high cycles and rising edges.
  Assumes the pin is sampled on ref_clk.
*/
`timescale 1ns/1ps

module cupwm_load (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Pin
  input wire pin,
  // Counts
  output integer high_cnt,
  output integer rise_cnt
);
  reg last_reg;
  initial begin
    high_cnt = 0;
    rise_cnt = 0;
    last_reg = 1'b0;
  end
  // Duty and period show up as high time and edge rate
  always @(posedge ref_clk) begin
    last_reg <= sys_rst ? 1'b0 : pin;
    if (!sys_rst && pin) high_cnt <= high_cnt + 1;
    if (!sys_rst && pin && !last_reg) rise_cnt <= rise_cnt + 1;
  end
endmodule // cupwm_load

//--- test/cupwm_top_tb.sv
/*
  Testbench of the compare unit PWM block: register tasks and waveform tests.
  Assumes cupwm_top, cupwm_load and cupwm_sva compiled before it.
*/
`timescale 1ns/1ps
`include "cupwm_defs.vh"

module cupwm_top_tb;
  reg ref_clk = 1'b0, sys_rst = 1'b1, reg_wr_strobe = 1'b0, reg_rd_strobe = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [15:0] reg_wr_data = 16'h0000, v;
  reg [6:0] timer_prescale_tick = 7'h00;
  reg [2:0] fault_in = 3'h0;
  reg ext_sync_pulse = 1'b0;
  wire [15:0] reg_rd_data_reg;
  wire pin, compare_irq;
  integer high_cnt, rise_cnt, n_mismatch = 0, samples_checked = 0, tcnt = 0, i;

  cupwm_top DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr_strobe(reg_wr_strobe), .reg_rd_strobe(reg_rd_strobe), .reg_rd_data_reg(reg_rd_data_reg),
    .timer_prescale_tick(timer_prescale_tick), .ext_sync_pulse(ext_sync_pulse), .fault_in(fault_in),
    .compare_output_pin_reg(pin), .compare_irq(compare_irq));
  // Pin reaches the load directly, standing in for the remap step
  cupwm_load u_load (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin(pin), .high_cnt(high_cnt), .rise_cnt(rise_cnt));

  initial forever #10 ref_clk = ~ref_clk;
  // Timer prescalers: timer i ticks every i+2 cycles
  always @(posedge ref_clk) begin
    tcnt <= tcnt + 1;
    for (i = 0; i < 7; i = i + 1) timer_prescale_tick[i] <= (tcnt % (i + 2)) == 0;
  end

  ////////////////////////////////////////////////////////////////////
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        $display("FAIL %s expected %h seen %h", nm, exp, seen);
        n_mismatch = n_mismatch + 1;
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge ref_clk);
      reg_wr_strobe <= 1'b1; reg_addr <= a; reg_wr_data <= d;
      @(posedge ref_clk);
      reg_wr_strobe <= 1'b0;
    end
  endtask
  task rdchk(input string nm, input [7:0] a, input [15:0] m, input [15:0] e);
    begin
      @(posedge ref_clk);
      reg_rd_strobe <= 1'b1; reg_addr <= a;
      @(posedge ref_clk);
      reg_rd_strobe <= 1'b0;
      #1 v = reg_rd_data_reg;
      chk(nm, v & m, e);
    end
  endtask
  // Settle, then count high cycles and rises over n cycles
  task measure(input string nm, input integer n, input integer eh, input integer er);
    integer h0, r0;
    begin
      repeat (10) @(posedge ref_clk);
      h0 = high_cnt; r0 = rise_cnt;
      repeat (n) @(posedge ref_clk);
      chk({nm, "_high"}, 16'(high_cnt - h0), 16'(eh));
      chk({nm, "_rise"}, 16'(rise_cnt - r0), 16'(er));
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask

  initial begin
    #(20 * 5000);
    n_mismatch = n_mismatch + 1;
    give_verdict;
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int a = 0; a <= 8'h1C; a = a + 4) rdchk("reset_value", 8'(a), 16'hFFFF, 16'h0000);
    $display("test reset values done");
    wr(`CUPWM_OFF_CTL_TWO, 16'hFF9F);
    rdchk("ctl_two", `CUPWM_OFF_CTL_TWO, 16'hFFFF, 16'h009F);
    wr(`CUPWM_OFF_CTL_TWO, 16'h001F);
    wr(`CUPWM_OFF_DUTY, 16'h0001);
    wr(`CUPWM_OFF_PERIOD, 16'h0003);
    wr(`CUPWM_OFF_MASK, 16'h0001);
    wr(`CUPWM_OFF_CTL_ONE, 16'h1C06);
    measure("edge", 40, 20, 10);
    chk("irq_period", {15'h0, compare_irq}, 16'h0001);
    rdchk("status", `CUPWM_OFF_STATUS, 16'h0003, 16'h0003);
    rdchk("count_ok", `CUPWM_OFF_COUNT, 16'hFFFC, 16'h0000);
    $display("test edge aligned done");
    wr(`CUPWM_OFF_DUTY, 16'h0002);
    rdchk("duty_soft", `CUPWM_OFF_DUTY, 16'hFFFF, 16'h0002);
    measure("edge_d2", 40, 10, 10);
    wr(`CUPWM_OFF_CTL_ONE, 16'h0806);
    measure("timer2", 80, 20, 5);
    $display("test buffer and clock done");
    wr(`CUPWM_OFF_CTL_ONE, 16'h1C00);
    wr(`CUPWM_OFF_DUTY, 16'h0001);
    wr(`CUPWM_OFF_CTL_ONE, 16'h1C07);
    measure("center", 60, 40, 10);
    $display("test center aligned done");
    wr(`CUPWM_OFF_MASK, 16'h0000);
    wr(`CUPWM_OFF_CTL_ONE, 16'h1C86);
    fault_in <= 3'h2;
    measure("fault_off", 40, 20, 10);
    fault_in <= 3'h3;
    measure("fault_on", 40, 0, 0);
    chk("irq_masked", {15'h0, compare_irq}, 16'h0000);
    wr(`CUPWM_OFF_MASK, 16'h0004);
    #1 chk("irq_fault", {15'h0, compare_irq}, 16'h0001);
    rdchk("status_fault", `CUPWM_OFF_STATUS, 16'h0004, 16'h0004);
    @(posedge ref_clk) fault_in <= 3'h0;
    measure("fault_gone", 40, 20, 10);
    $display("test fault done");
    // Trigger bit set: counter held until armed, then runs past the period
    wr(`CUPWM_OFF_CTL_TWO, 16'h009F);
    rdchk("trig_count", `CUPWM_OFF_COUNT, 16'hFFFF, 16'h0000);
    measure("trig_hold", 20, 0, 0);
    ext_sync_pulse <= 1'b1;
    @(posedge ref_clk) ext_sync_pulse <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rdchk("trig_free", `CUPWM_OFF_COUNT, 16'hFFFF, 16'h0008);
    $display("test trigger done");
    wr(`CUPWM_OFF_CTL_ONE, 16'h1C00);
    repeat (3) @(posedge ref_clk);
    rdchk("status_all", `CUPWM_OFF_STATUS, 16'hFFFF, 16'h0007);
    rdchk("status_empty", `CUPWM_OFF_STATUS, 16'hFFFF, 16'h0000);
    chk("irq_clear", {15'h0, compare_irq}, 16'h0000);
    rdchk("count_off", `CUPWM_OFF_COUNT, 16'hFFFF, 16'h0000);
    measure("off", 20, 0, 0);
    $display("test read clear done");
    give_verdict;
  end
endmodule // cupwm_top_tb

bind cupwm_top cupwm_sva #(.CNT_W(CNT_W), .FLT_N(FLT_N)) u_sva (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_strobe(reg_wr_strobe),
  .reg_rd_strobe(reg_rd_strobe), .reg_rd_data_reg(reg_rd_data_reg), .fault_in(fault_in),
  .compare_output_pin_reg(compare_output_pin_reg), .compare_irq(compare_irq));
